// [hw/sfrc_pin_sync.sv]
// two-flop synchronisers for the serial pins and straps, with serial clock edge pulses
module sfrc_pin_sync (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic [15:0] nv_in,
    output logic sclk_rise_out,
    output logic sclk_fall_out,
    output logic cs_n_out,
    output logic si_out,
    output logic [15:0] nv_out
);
    import sfrc_pkg::*;

    logic [2:0] sclk_s1_ff, sclk_s2_ff;
    logic sclk_q_ff;
    logic [15:0] nv_s1_ff;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // idle levels: select high, clock low, so no false edge follows reset
            sclk_s1_ff <= 3'h4;
            sclk_s2_ff <= 3'h4;
            sclk_q_ff <= 1'b0;
        end else begin
            sclk_s1_ff <= {cs_n_in, si_in, sclk_in};
            sclk_s2_ff <= sclk_s1_ff;
            sclk_q_ff <= sclk_s2_ff[0];
        end
    end

    // straps idle at the factory pattern until the synchroniser has filled
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nv_s1_ff <= NVCR_FACTORY;
            nv_out <= NVCR_FACTORY;
        end else begin
            nv_s1_ff <= nv_in;
            nv_out <= nv_s1_ff;
        end
    end

    assign sclk_rise_out = sclk_s2_ff[0] & ~sclk_q_ff;
    assign sclk_fall_out = ~sclk_s2_ff[0] & sclk_q_ff;
    assign si_out = sclk_s2_ff[1];
    assign cs_n_out = sclk_s2_ff[2];
endmodule

// [hw/sfrc_pkg.sv]
// constants, field layout and state codes for the flash read-path configuration block
package sfrc_pkg;
    localparam logic [7:0] CMD_RD_VCR = 8'h85;
    localparam logic [7:0] CMD_WR_VCR = 8'h81;
    localparam logic [7:0] CMD_FAST_RD = 8'h0b;
    localparam int VCR_DUMMY_HI = 7;
    localparam int VCR_DUMMY_LO = 4;
    localparam int VCR_XIP_BIT = 3;
    localparam int VCR_RSVD_BIT = 2;
    localparam logic [7:0] VCR_RESET = 8'hfb;
    localparam logic [15:0] NVCR_FACTORY = 16'hffff;
    localparam int NV_DUMMY_HI = 15;
    localparam int NV_DUMMY_LO = 12;
    localparam int NV_QUAD_BIT = 3;
    localparam int NV_DUAL_BIT = 2;
    localparam logic [3:0] DUMMY_CODE_DFLT_A = 4'h0;
    localparam logic [3:0] DUMMY_CODE_DFLT_B = 4'hf;
    localparam logic [3:0] DUMMY_DEFAULT_CYCLES = 4'ha;
    localparam logic [1:0] WRAP_16 = 2'h0;
    localparam logic [1:0] WRAP_32 = 2'h1;
    localparam logic [1:0] WRAP_64 = 2'h2;
    localparam logic [1:0] WRAP_SEQ = 2'h3;
    localparam logic [23:0] MASK_16 = 24'h00000f;
    localparam logic [23:0] MASK_32 = 24'h00001f;
    localparam logic [23:0] MASK_64 = 24'h00003f;
    localparam logic [23:0] MASK_SEQ = 24'hffffff;
    localparam logic [4:0] CMD_LAST_BIT = 5'h07;
    localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
    localparam logic [2:0] BOOT_LOAD_CYCLES = 3'h3;

    typedef enum logic [6:0] {
        ST_CMD = 7'h01,
        ST_ADDR = 7'h02,
        ST_DUMMY = 7'h04,
        ST_DATA = 7'h08,
        ST_RD_CFG = 7'h10,
        ST_WR_CFG = 7'h20,
        ST_IGNORE = 7'h40
    } sfrc_state_t;
endpackage

// [hw/sfrc_read_config.sv]
// Function
// - dummy clocks after each fast read come from config bits 7:4.
// - dummy codes 0000 and 1111 both select the default count.
// - at power-on nonvolatile bit 3 low selects quad, else bit 2 low dual.
// - config bit 3 low enables execute in place; forced on for some variants.
// - wrap field 00/01/10 wraps 16/32/64 bytes; 11 reads sequentially.
// - wrapped output starts at issued address and loops inside its block.
// - wrap start is the three address bytes following the command.
// - config written only by its command, applied when that command ends.
// - nonvolatile bits 15:12 become config bits 7:4 after power-on; wrap set to 11.
module sfrc_read_config #(
    parameter bit XIP_FORCED = 1'b0
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic [15:0] nv_config_in,
    input wire logic [7:0] rd_data_in,
    output logic so_out,
    output logic so_oe_out,
    output logic [23:0] rd_addr_out,
    output logic [7:0] vcr_out,
    output logic execute_in_place_out,
    output logic quad_mode_out,
    output logic dual_mode_out,
    output logic boot_done_out
);
    import sfrc_pkg::*;

    logic sclk_rise, sclk_fall, cs_n, si;
    logic [15:0] nv;
    sfrc_state_t state_ff;
    logic [4:0] bcnt_ff;
    logic [23:0] sh_ff;
    logic [7:0] wr_val_ff;
    logic wr_pend_ff, cs_q_ff;
    logic [2:0] boot_cnt_ff, obit_ff;
    logic [7:0] osh_ff;
    logic [3:0] dummy_code, eff_dummy;
    logic [7:0] cmd_byte, out_byte;
    logic wr_capture, cs_rise, boot_load;

    sfrc_pin_sync u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .sclk_in(sclk_in),
        .cs_n_in(cs_n_in),
        .si_in(si_in),
        .nv_in(nv_config_in),
        .sclk_rise_out(sclk_rise),
        .sclk_fall_out(sclk_fall),
        .cs_n_out(cs_n),
        .si_out(si),
        .nv_out(nv)
    );

    function automatic logic [23:0] wrap_next(logic [23:0] a, logic [1:0] w);
        logic [23:0] m;
        logic [23:0] inc;
        inc = a + 24'h000001;
        case (w)
            WRAP_16: m = MASK_16;
            WRAP_32: m = MASK_32;
            WRAP_64: m = MASK_64;
            default: m = MASK_SEQ;
        endcase
        return (a & ~m) | (inc & m);
    endfunction

    assign dummy_code = vcr_out[VCR_DUMMY_HI:VCR_DUMMY_LO];
    assign eff_dummy = (dummy_code == DUMMY_CODE_DFLT_A || dummy_code == DUMMY_CODE_DFLT_B) ?
        DUMMY_DEFAULT_CYCLES : dummy_code;
    assign cmd_byte = {sh_ff[6:0], si};
    assign wr_capture = sclk_rise && !cs_n && state_ff == ST_WR_CFG && bcnt_ff == CMD_LAST_BIT;
    assign cs_rise = cs_n && !cs_q_ff;
    assign boot_load = !boot_done_out && boot_cnt_ff == BOOT_LOAD_CYCLES;
    assign out_byte = (state_ff == ST_DATA) ? rd_data_in : vcr_out;

    // command decode, address capture, dummy count and data address walk
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= ST_CMD;
            bcnt_ff <= 5'h00;
            sh_ff <= 24'h000000;
            rd_addr_out <= 24'h000000;
        end else if (cs_n) begin
            state_ff <= ST_CMD;
            bcnt_ff <= 5'h00;
        end else if (sclk_rise) begin
            unique case (state_ff)
                ST_CMD: begin
                    sh_ff <= {sh_ff[22:0], si};
                    bcnt_ff <= (bcnt_ff == CMD_LAST_BIT) ? 5'h00 : bcnt_ff + 5'h01;
                    if (bcnt_ff == CMD_LAST_BIT) begin
                        // only the dedicated commands touch the register
                        if (cmd_byte == CMD_RD_VCR) state_ff <= ST_RD_CFG;
                        else if (cmd_byte == CMD_WR_VCR) state_ff <= ST_WR_CFG;
                        else if (cmd_byte == CMD_FAST_RD) state_ff <= ST_ADDR;
                        else state_ff <= ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    sh_ff <= {sh_ff[22:0], si};
                    bcnt_ff <= (bcnt_ff == ADDR_LAST_BIT) ? 5'h00 : bcnt_ff + 5'h01;
                    if (bcnt_ff == ADDR_LAST_BIT) begin
                        rd_addr_out <= {sh_ff[22:0], si};
                        state_ff <= ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (bcnt_ff[3:0] == eff_dummy - 4'h1) begin
                        state_ff <= ST_DATA;
                        bcnt_ff <= 5'h00;
                    end else begin
                        bcnt_ff <= bcnt_ff + 5'h01;
                    end
                end
                ST_DATA: begin
                    bcnt_ff <= (bcnt_ff == CMD_LAST_BIT) ? 5'h00 : bcnt_ff + 5'h01;
                    if (bcnt_ff == CMD_LAST_BIT) begin
                        rd_addr_out <= wrap_next(rd_addr_out, vcr_out[1:0]);
                    end
                end
                ST_WR_CFG: begin
                    sh_ff <= {sh_ff[22:0], si};
                    bcnt_ff <= bcnt_ff + 5'h01;
                    if (bcnt_ff == CMD_LAST_BIT) state_ff <= ST_IGNORE;
                end
                ST_RD_CFG, ST_IGNORE: begin
                    bcnt_ff <= 5'h00;
                end
            endcase
        end
    end

    // power-on load from the nonvolatile copy, then write-command updates
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vcr_out <= VCR_RESET;
            wr_val_ff <= VCR_RESET;
            wr_pend_ff <= 1'b0;
            cs_q_ff <= 1'b1;
            boot_cnt_ff <= 3'h0;
            boot_done_out <= 1'b0;
            quad_mode_out <= 1'b0;
            dual_mode_out <= 1'b0;
        end else begin
            cs_q_ff <= cs_n;
            if (!boot_done_out) boot_cnt_ff <= boot_cnt_ff + 3'h1;
            if (boot_load) begin
                boot_done_out <= 1'b1;
                vcr_out[VCR_DUMMY_HI:VCR_DUMMY_LO] <= nv[NV_DUMMY_HI:NV_DUMMY_LO];
                vcr_out[1:0] <= WRAP_SEQ;
                quad_mode_out <= !nv[NV_QUAD_BIT];
                dual_mode_out <= nv[NV_QUAD_BIT] && !nv[NV_DUAL_BIT];
            end else if (wr_capture) begin
                wr_val_ff <= cmd_byte;
                wr_val_ff[VCR_RSVD_BIT] <= 1'b0;
                wr_pend_ff <= 1'b1;
            end else if (cs_rise && wr_pend_ff) begin
                vcr_out <= wr_val_ff; // applied as the command completes
                wr_pend_ff <= 1'b0;
            end else if (cs_rise) begin
                wr_pend_ff <= 1'b0;
            end
        end
    end

    // variants with the forced option run execute in place whatever bit 3 says
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) execute_in_place_out <= 1'b0;
        else execute_in_place_out <= XIP_FORCED || !vcr_out[VCR_XIP_BIT];
    end

    // serial output shifts on falling edges so the host samples on rising ones
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
            osh_ff <= 8'h00;
            obit_ff <= 3'h0;
        end else begin
            so_oe_out <= !cs_n && (state_ff == ST_DATA || state_ff == ST_RD_CFG);
            if (cs_n) begin
                obit_ff <= 3'h0;
            end else if (sclk_fall && (state_ff == ST_DATA || state_ff == ST_RD_CFG)) begin
                obit_ff <= obit_ff + 3'h1;
                if (obit_ff == 3'h0) begin
                    so_out <= out_byte[7];
                    osh_ff <= {out_byte[6:0], 1'b0};
                end else begin
                    so_out <= osh_ff[7];
                    osh_ff <= {osh_ff[6:0], 1'b0};
                end
            end
        end
    end

    dummy_len_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_ff == ST_DUMMY && !cs_n && sclk_rise && bcnt_ff[3:0] == eff_dummy - 4'h1)
        |=> state_ff == ST_DATA && bcnt_ff == 5'h00)
        else $error("dummy phase did not end at programmed count");
    dummy_dflt_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_ff == ST_DUMMY && (dummy_code == 4'h0 || dummy_code == 4'hf))
        |-> bcnt_ff < 5'h0a)
        else $error("default dummy code ran past ten clocks");
    proto_sel_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(boot_done_out) |-> quad_mode_out == !$past(nv[3])
        && dual_mode_out == ($past(nv[3]) && !$past(nv[2])))
        else $error("protocol selection mismatch at power-on");
    xip_sel_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ##1 execute_in_place_out == (XIP_FORCED || !$past(vcr_out[3])))
        else $error("execute in place does not follow config");
    wrap_bound_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_ff == ST_DATA && vcr_out[1:0] != WRAP_SEQ && $changed(rd_addr_out))
        |-> rd_addr_out[23:6] == $past(rd_addr_out[23:6]))
        else $error("wrapped read left its aligned block");
    wrap_loop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_ff == ST_DATA && vcr_out[1:0] == WRAP_16 && $changed(rd_addr_out))
        |-> rd_addr_out == {$past(rd_addr_out[23:4]), $past(rd_addr_out[3:0]) + 4'h1})
        else $error("16-byte wrap sequence wrong");
    wrap_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_ff == ST_ADDR && !cs_n && sclk_rise && bcnt_ff == ADDR_LAST_BIT)
        |=> rd_addr_out == $past({sh_ff[22:0], si}))
        else $error("read start address not captured");
    cfg_commit_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $changed(vcr_out) |-> $past(cs_rise && wr_pend_ff) || $past(boot_load))
        else $error("config changed outside write completion");
    boot_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        boot_load |=> vcr_out[7:4] == $past(nv[15:12]) && vcr_out[1:0] == 2'h3)
        else $error("power-on config load wrong");
endmodule

// [tb/sfrc_host_model.sv]
// host controller model: mode 0 serial master driving the flash pins
module sfrc_host_model (
    input wire logic clk_in,
    input wire logic so_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic si_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // n bits of tx, msb first; so taken at the rising sclk edge
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b0;
            si_out = tx[7 - i];
            repeat (4) @(negedge clk_in);
            sclk_out = 1'b1;
            rx = {rx[6:0], so_in};
            repeat (4) @(negedge clk_in);
        end
    endtask
    // 12.5 MHz link sits below every dummy count limit
    task automatic dummy(input int n);
        logic [7:0] r;
        for (int i = 0; i < n; i++) xfer(8'(i * 8'h93), 1, r);
    endtask
    task automatic open_frame();
        @(negedge clk_in);
        cs_n_out = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask
    // si inverted after release so a stale level is never trusted
    task automatic close_frame();
        sclk_out = 1'b0;
        repeat (3) @(negedge clk_in);
        cs_n_out = 1'b1;
        si_out = ~si_out;
        repeat (8) @(negedge clk_in);
    endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the flash read-path configuration block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfrc_pkg::*;
    function automatic logic [7:0] mem_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
    endfunction
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] nv = NVCR_FACTORY;
    wire sclk, cs_n, si, so_line;
    logic so, so_oe, execute_in_place, quad, dual, boot_done;
    logic [23:0] rd_addr;
    logic [7:0] vcr, rx;
    wire [7:0] rd_data = mem_byte(rd_addr);
    int miscompares = 0;
    int num_checks = 0;
    int seed = 32'h5b73;
    always #5 clk = ~clk;
    // released line shows the inverse of the last bit, so a late enable reads wrong
    assign so_line = so_oe ? so : ~so;
    sfrc_host_model sfrc_host_model_i (.clk_in(clk), .so_in(so_line), .sclk_out(sclk),
        .cs_n_out(cs_n), .si_out(si));
    sfrc_read_config sfrc_read_config_i (.clk_in(clk), .rstn_in(rstn), .sclk_in(sclk),
        .cs_n_in(cs_n), .si_in(si), .nv_config_in(nv), .rd_data_in(rd_data), .so_out(so),
        .so_oe_out(so_oe), .rd_addr_out(rd_addr), .vcr_out(vcr), .execute_in_place_out(execute_in_place),
        .quad_mode_out(quad), .dual_mode_out(dual), .boot_done_out(boot_done));
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic reset_boot(input logic [15:0] v);
        @(negedge clk);
        rstn = 1'b0;
        nv = v;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 20 && boot_done !== 1'b1; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        check({16'h0, vcr}, {16'h0, v[15:12], 4'hb}, "boot vcr");
        check({23'h0, quad}, {23'h0, ~v[3]}, "quad");
        check({23'h0, dual}, {23'h0, v[3] & ~v[2]}, "dual");
        check({23'h0, execute_in_place}, 24'h0, "boot xip");
        check({23'h0, boot_done}, 24'h1, "boot done");
    endtask
    task automatic wr_cfg(input logic [7:0] cmd, input logic [7:0] v, input int n);
        sfrc_host_model_i.open_frame();
        sfrc_host_model_i.xfer(cmd, 8, rx);
        sfrc_host_model_i.xfer(v, n, rx);
        sfrc_host_model_i.close_frame();
    endtask
    task automatic rd_cfg(input logic [7:0] e);
        sfrc_host_model_i.open_frame();
        sfrc_host_model_i.xfer(CMD_RD_VCR, 8, rx);
        repeat (2) begin
            sfrc_host_model_i.xfer(8'h00, 8, rx);
            check({16'h0, rx}, {16'h0, e}, "cfg read");
        end
        sfrc_host_model_i.close_frame();
    endtask
    task automatic fast_rd(input logic [23:0] a, input logic [3:0] code, input int w);
        logic [23:0] m;
        logic [23:0] e;
        int nd;
        m = (w == 3) ? 24'hffffff : (24'h10 << w) - 24'h1;
        sfrc_host_model_i.open_frame();
        sfrc_host_model_i.xfer(CMD_FAST_RD, 8, rx);
        for (int i = 2; i >= 0; i--) sfrc_host_model_i.xfer(a[8*i +: 8], 8, rx);
        nd = (code == 4'h0 || code == 4'hf) ? 10 : int'(code);
        sfrc_host_model_i.dummy(nd);
        for (int i = 0; i < 4; i++) begin
            e = (a & ~m) | ((a + 24'(i)) & m);
            sfrc_host_model_i.xfer(8'h00, 8, rx);
            check({16'h0, rx}, {16'h0, mem_byte(e)}, "read byte");
        end
        sfrc_host_model_i.close_frame();
    endtask
    initial begin
        logic [7:0] v;
        logic [7:0] ev;
        logic [15:0] n;
        logic [23:0] a;
        logic [3:0] codes [5];
        codes = '{4'h0, 4'hf, 4'h1, 4'h7, 4'hd};
        ev = 8'h00;
        for (int k = 0; k < 4; k++) begin
            n = 16'($random(seed));
            n[3:2] = 2'(k);
            reset_boot(k == 3 ? NVCR_FACTORY : n);
        end
        for (int w = 0; w < 4; w++) begin
            foreach (codes[j]) begin
                // bit 2 sent high: the reserved bit must read back 0
                v = {codes[j], 1'($random(seed)), 1'b1, 2'(w)};
                ev = {v[7:3], 1'b0, v[1:0]};
                wr_cfg(CMD_WR_VCR, v, 8);
                check({16'h0, vcr}, {16'h0, ev}, "cfg write");
                check({23'h0, execute_in_place}, {23'h0, ~v[3]}, "xip");
                a = 24'($random(seed));
                a[5:0] = 6'((24'h10 << w) - 24'h2);
                fast_rd(a, codes[j], w);
            end
            rd_cfg(ev);
        end
        wr_cfg(CMD_WR_VCR, 8'h5c, 4);
        wr_cfg(8'h5a, 8'h12, 8);
        check({16'h0, vcr}, {16'h0, ev}, "vcr kept");
        rd_cfg(ev);
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule
